//--- image_edge_if.sv
// Carrier between the decoder top and its rising edge finder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface image_edge_if;
  logic [31:0] image;
  logic        strobe;
  logic        enable;
  logic [31:0] pulses;

  modport src
  (
    output image,
    output strobe,
    output enable,
    input  pulses
  );

  modport det
  (
    input  image,
    input  strobe,
    input  enable,
    output pulses
  );
endinterface

//--- rising_edge_finder.sv
// Rising edge finder: compares each newly received image with the previous one.
// Assumes strobe is high for one cycle when a new image has been stored.
`timescale 1ns/1ps
`include "robot_image_defines.svh"

module rising_edge_finder
(
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  image_edge_if.det  edges
);

  robot_image_pkg::edge_state_s state_q;
  robot_image_pkg::edge_state_s state_d;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // The previous image is tracked even while disabled, so enabling later does
  // not fire pulses for bits that were already high.
  always_comb
  begin
    state_d        = state_q;
    state_d.pulses = 32'h00000000;
    if (edges.strobe)
    begin
      state_d.last = edges.image;
      if (edges.enable)
      begin
        state_d.pulses = edges.image & ~state_q.last & `RID_EDGE_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign edges.pulses = state_q.pulses;

endmodule

//--- robot_image_assertions.sv
// Concurrent checks on the robot image decoder ports.
// Assumes one master that idles during every data phase.
`timescale 1ns/1ps

module robot_image_assertions
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        weld_start_pulse,
  input wire logic        robot_ready,
  input wire logic [4:0]  work_mode,
  input wire logic        gas_on_pulse,
  input wire logic [1:0]  process_line,
  input wire logic        teach_mode,
  input wire logic        sense_abort_pulse
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  logic wr_w;
  assign wr_w = hsel && hready && htrans[1] && hwrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Three edges without a taken write leave no room for a new pulse.
  sequence s_quiet;
    !wr_w [*3];
  endsequence
  property p_single(sig);
    sig |=> !sig;
  endproperty
  a_start_single: assert property (p_single(weld_start_pulse))
    else $error("weld start pulse longer than one cycle");
  a_gas_single: assert property (p_single(gas_on_pulse))
    else $error("gas pulse longer than one cycle");
  a_start_cause: assert property (weld_start_pulse |-> $past(hwdata[0], 2))
    else $error("weld start pulse without bit 0 written");
  a_abort_cause: assert property (sense_abort_pulse |-> $past(hwdata[30], 2))
    else $error("sense abort pulse without bit 30 written");
  a_idle_no_pulse: assert property (s_quiet |=> !gas_on_pulse)
    else $error("pulse with no new image");
  a_mode_change: assert property ($changed(work_mode) |-> $past(wr_w, 2))
    else $error("mode changed without a write");
  a_line_change: assert property ($changed(process_line) |-> $past(wr_w, 2))
    else $error("process line changed without a write");
  a_teach_change: assert property ($changed(teach_mode) |-> $past(wr_w, 2))
    else $error("teach changed without a write");
  a_reset_quiet: assert property ($rose(rst_n) |-> !robot_ready && work_mode == 5'h00)
    else $error("levels active out of reset");
endmodule

bind robot_image_decoder robot_image_assertions chk (.sys_clk, .rst_n, .hsel, .htrans,
  .hwrite, .hwdata, .hready, .weld_start_pulse, .robot_ready, .work_mode, .gas_on_pulse,
  .process_line, .teach_mode, .sense_abort_pulse);

//--- robot_image_decoder.sv
// Robot input image decoder: AHB-Lite slave holding the first image word,
// turning command edges into one-cycle pulses and passing level fields on.
// Assumes a single AHB-Lite master, word transfers only, and that the fieldbus
// stack writes each received image word into the image register.
//
// Functional notes
// - Image flows robot to power source only; robot supplies every command bit.
// - Unsigned words read back as whole numbers from zero to 65535.
// - Signed words read back sign extended, -32768 to 32767.
// - Rising edge on bit 0 starts a weld; held level ignored.
// - Bit 1 high means the robot is ready.
// - Bits 2..6 are the operating mode level field, bit 2 least significant.
// - Rising edge on bit 8 turns shielding gas on.
// - Rising edges on bits 9 and 10 feed wire forward and retract.
// - Rising edge on bit 11 acknowledges and clears a pending fault.
// - Contact sensing is active while bit 12 is high.
// - Rising edge on bit 13 triggers torch blow-out.
// - Bits 14..15 select the process line, bit 14 least significant.
// - Weld simulation without arc is active while bit 16 is high.
// - Synchronous pulse operation is enabled while bit 17 is high.
// - Wire brake is engaged while bit 22 is high.
// - Torch-body exchange is requested while bit 23 is high.
// - Teach operation is active while bit 25 is high.
// - Rising edges on bits 29 and 30 start and abort wire position sensing.
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "robot_image_defines.svh"

module robot_image_decoder
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             weld_start_pulse,
  output logic             robot_ready,
  output logic      [4:0]  work_mode,
  output logic             gas_on_pulse,
  output logic             wire_fwd_pulse,
  output logic             wire_back_pulse,
  output logic             fault_ack_pulse,
  output logic             touch_sense,
  output logic             blow_out_pulse,
  output logic      [1:0]  process_line,
  output logic             weld_sim,
  output logic             sync_pulse,
  output logic             wire_brake,
  output logic             torch_xchg,
  output logic             teach_mode,
  output logic             sense_start_pulse,
  output logic             sense_abort_pulse
);

  robot_image_pkg::decoder_state_s state_q;
  robot_image_pkg::decoder_state_s state_d;

  image_edge_if edges ();

  logic        addr_phase;
  logic [31:0] levels;
  logic [31:0] pulses;
  logic [31:0] read_mux;
  logic [31:0] unsigned_word;
  logic [31:0] signed_word;

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  assign edges.image  = state_q.image;
  assign edges.strobe = state_q.strobe;
  assign edges.enable = state_q.enable;
  assign pulses       = edges.pulses;

  rising_edge_finder u_edges
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .edges   (edges)
  );

  // ---------------------------------------------------------------------------
  // Decoded views and read multiplexer
  // ---------------------------------------------------------------------------
  // Level fields are forced low while decoding is disabled, so the welding
  // control never acts on an image that software has not released.
  assign levels = state_q.enable ? (state_q.image & `RID_LEVEL_MASK) : 32'h00000000;

  assign unsigned_word = {16'h0000, state_q.word};
  assign signed_word   = {{16{state_q.word[`RID_WORD_MSB]}}, state_q.word};

  always_comb
  begin
    read_mux = 32'h00000000;
    unique case (haddr[`RID_ADDR_W-1:0])
      `RID_OFS_IMAGE:    read_mux = state_q.image;
      `RID_OFS_LEVELS:   read_mux = levels;
      `RID_OFS_EVENTS:   read_mux = state_q.events;
      `RID_OFS_CONTROL:  read_mux = {31'h00000000, state_q.enable};
      `RID_OFS_WORD:     read_mux = {16'h0000, state_q.word};
      `RID_OFS_UNSIGNED: read_mux = unsigned_word;
      `RID_OFS_SIGNED:   read_mux = signed_word;
      default:           read_mux = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Bus slave and register file
  // ---------------------------------------------------------------------------
  // Read data is captured in the address phase. This is safe because the
  // master idles during every data phase, so no write can overlap a read.
  assign addr_phase = hsel && hready && htrans[1];

  always_comb
  begin
    state_d        = state_q;
    state_d.strobe = 1'b0;

    if (addr_phase)
    begin
      state_d.wr_pend = hwrite;
      state_d.addr    = haddr[`RID_ADDR_W-1:0];
      state_d.rdata   = hwrite ? 32'h00000000 : read_mux;
    end
    else if (hready)
    begin
      state_d.wr_pend = 1'b0;
    end

    // Sticky copy of every pulse; a new pulse wins over a clear in the same cycle.
    state_d.events = state_q.events | pulses;

    if (state_q.wr_pend)
    begin
      unique case (state_q.addr)
        `RID_OFS_IMAGE:
        begin
          state_d.image  = hwdata & `RID_ASSIGNED_MASK;
          state_d.strobe = 1'b1;
        end
        `RID_OFS_EVENTS:
        begin
          state_d.events = (state_q.events & ~hwdata) | pulses;
        end
        `RID_OFS_CONTROL:
        begin
          state_d.enable = hwdata[`RID_CTRL_ENABLE];
        end
        `RID_OFS_WORD:
        begin
          state_d.word = hwdata[`RID_WORD_MSB:0];
        end
        default:
        begin
          state_d.strobe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q        <= '0;
      state_q.image  <= `RID_RST_IMAGE;
      state_q.word   <= `RID_RST_WORD;
      state_q.enable <= `RID_RST_ENABLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Zero wait states and an OKAY response on every transfer; hsize is not
  // checked, so a narrower access acts on the whole word.
  assign hrdata    = state_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------------------
  // Command pulses
  // ---------------------------------------------------------------------------
  assign weld_start_pulse  = pulses[`RID_BIT_WELD_START];
  assign gas_on_pulse      = pulses[`RID_BIT_GAS_ON];
  assign wire_fwd_pulse    = pulses[`RID_BIT_WIRE_FWD];
  assign wire_back_pulse   = pulses[`RID_BIT_WIRE_BACK];
  assign fault_ack_pulse   = pulses[`RID_BIT_FAULT_ACK];
  assign blow_out_pulse    = pulses[`RID_BIT_BLOW_OUT];
  assign sense_start_pulse = pulses[`RID_BIT_SENSE_START];
  assign sense_abort_pulse = pulses[`RID_BIT_SENSE_ABORT];

  // ---------------------------------------------------------------------------
  // Level signals and selection fields
  // ---------------------------------------------------------------------------
  // Scaled quantities arrive already multiplied by the robot; this block only
  // widens them and never rescales.
  assign robot_ready  = levels[`RID_BIT_ROBOT_READY];
  assign work_mode    = levels[`RID_MODE_MSB:`RID_MODE_LSB];
  assign touch_sense  = levels[`RID_BIT_TOUCH_SENSE];
  assign process_line = levels[`RID_LINE_MSB:`RID_LINE_LSB];
  assign weld_sim     = levels[`RID_BIT_WELD_SIM];
  assign sync_pulse   = levels[`RID_BIT_SYNC_PULSE];
  assign wire_brake   = levels[`RID_BIT_WIRE_BRAKE];
  assign torch_xchg   = levels[`RID_BIT_TORCH_XCHG];
  assign teach_mode   = levels[`RID_BIT_TEACH];

endmodule

//--- robot_image_defines.svh
// Offsets, bit positions, masks and reset values of the robot input image decoder.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef ROBOT_IMAGE_DEFINES_SVH
`define ROBOT_IMAGE_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register byte offsets within the slave window
// ---------------------------------------------------------------------------
`define RID_ADDR_W           8
`define RID_OFS_IMAGE        8'h00
`define RID_OFS_LEVELS       8'h04
`define RID_OFS_EVENTS       8'h08
`define RID_OFS_CONTROL      8'h0C
`define RID_OFS_WORD         8'h10
`define RID_OFS_UNSIGNED     8'h14
`define RID_OFS_SIGNED       8'h18

// ---------------------------------------------------------------------------
// Image bit positions
// ---------------------------------------------------------------------------
`define RID_BIT_WELD_START   0
`define RID_BIT_ROBOT_READY  1
`define RID_MODE_LSB         2
`define RID_MODE_MSB         6
`define RID_BIT_GAS_ON       8
`define RID_BIT_WIRE_FWD     9
`define RID_BIT_WIRE_BACK    10
`define RID_BIT_FAULT_ACK    11
`define RID_BIT_TOUCH_SENSE  12
`define RID_BIT_BLOW_OUT     13
`define RID_LINE_LSB         14
`define RID_LINE_MSB         15
`define RID_BIT_WELD_SIM     16
`define RID_BIT_SYNC_PULSE   17
`define RID_BIT_WIRE_BRAKE   22
`define RID_BIT_TORCH_XCHG   23
`define RID_BIT_TEACH        25
`define RID_BIT_SENSE_START  29
`define RID_BIT_SENSE_ABORT  30

// ---------------------------------------------------------------------------
// Masks, field positions and reset values
// ---------------------------------------------------------------------------
`define RID_EDGE_MASK        32'h60002F01
`define RID_LEVEL_MASK       32'h02C3D07E
`define RID_ASSIGNED_MASK    32'h62C3FF7F
`define RID_CTRL_ENABLE      0
`define RID_WORD_MSB         15
`define RID_RST_IMAGE        32'h00000000
`define RID_RST_WORD         16'h0000
`define RID_RST_ENABLE       1'h0

`endif

//--- robot_image_pkg.sv
// Types shared by the robot input image decoder modules.
// Assumes robot_image_defines.svh is available on the include path.
`include "robot_image_defines.svh"

package robot_image_pkg;

  // ---------------------------------------------------------------------------
  // State of the rising edge finder
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] last;
    logic [31:0] pulses;
  } edge_state_s;

  // ---------------------------------------------------------------------------
  // State of the decoder top
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]             image;
    logic                    strobe;
    logic                    enable;
    logic [15:0]             word;
    logic [31:0]             events;
    logic                    wr_pend;
    logic [`RID_ADDR_W-1:0]  addr;
    logic [31:0]             rdata;
  } decoder_state_s;

endpackage

//--- robot_master.sv
// Robot controller model: the one AHB-Lite master that writes the image.
// Assumes hready is the decoder's hreadyout and calls start just after an edge.
`timescale 1ns/1ps

module robot_master
(
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             stuck
);
  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  initial
  begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    stuck  = 1'h0;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1 && n < 64)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (hready !== 1'b1)
      stuck <= 1'b1;
  endtask
  // Every command bit comes from this model; it flips stale data so none is reused.
  task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    wait_ready();
    htrans <= 2'h0;
    if (wr)
      hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the robot image decoder.
// Assumes the decoder is the only slave and the robot model the only master.
`timescale 1ns/1ps

module testbench;
  logic        sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, stuck;
  logic        weld_start_pulse, robot_ready, gas_on_pulse, wire_fwd_pulse, wire_back_pulse;
  logic        fault_ack_pulse, touch_sense, blow_out_pulse, weld_sim, sync_pulse, wire_brake;
  logic        torch_xchg, teach_mode, sense_start_pulse, sense_abort_pulse;
  logic [1:0]  htrans, process_line;
  logic [2:0]  hsize;
  logic [4:0]  work_mode;
  logic [7:0]  pulse_v, pulse_last;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [15:0] words [2] = '{16'h8000, 16'hFFC0};
  int          fail_count, checks_done, pulse_cnt, n;
  int          edge_bits [8] = '{0, 8, 9, 10, 11, 13, 29, 30};

  robot_image_decoder uut (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .weld_start_pulse, .robot_ready, .work_mode,
    .gas_on_pulse, .wire_fwd_pulse, .wire_back_pulse, .fault_ack_pulse, .touch_sense,
    .blow_out_pulse, .process_line, .weld_sim, .sync_pulse, .wire_brake, .torch_xchg,
    .teach_mode, .sense_start_pulse, .sense_abort_pulse);
  robot_master pm (.sys_clk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .stuck);

  // ---------------------------------------------------------------------------
  // Clock, pulse tally and tasks
  // ---------------------------------------------------------------------------
  assign hready = hreadyout;
  assign pulse_v = {sense_abort_pulse, sense_start_pulse, blow_out_pulse, fault_ack_pulse,
                    wire_back_pulse, wire_fwd_pulse, gas_on_pulse, weld_start_pulse};
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    pulse_cnt <= pulse_cnt + $countones(pulse_v);
    if (pulse_v != 8'h00)
      pulse_last <= pulse_v;
  end
  // A bus that never answers is a mismatch, so a hang can never end in a pass.
  always @(posedge stuck)
  begin
    fail_count++;
    results();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    pm.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [31:0] a);
    pm.xfer(a, 1'b0, 32'h0, rd_q);
  endtask
  task automatic levels(input logic [31:0] exp);
    repeat (2) @(posedge sys_clk);
    check({teach_mode, torch_xchg, wire_brake, sync_pulse, weld_sim, touch_sense, robot_ready,
           process_line, work_mode}, exp);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    pulse_cnt = 0;
    pulse_last = 8'h00;
    fail_count = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    levels(32'h0);
    wr(32'h0C, 32'h1);
    rd(32'h0C);
    check(rd_q, 32'h1);
    foreach (edge_bits[i])
    begin
      n = pulse_cnt;
      wr(32'h0, 32'h1 << edge_bits[i]);
      wr(32'h0, 32'h1 << edge_bits[i]);
      repeat (4) @(posedge sys_clk);
      check(pulse_cnt - n, 32'h1);
      check(pulse_last, 32'h1 << i);
    end
    rd(32'h08);
    check(rd_q, 32'h60002F01);
    wr(32'h08, 32'hFFFFFFFF);
    rd(32'h08);
    check(rd_q, 32'h0);
    wr(32'h0, 32'hFFFFFFFF);
    levels(32'h3FFF);
    rd(32'h0);
    check(rd_q, 32'h62C3FF7F);
    wr(32'h0, 32'h02404054);
    levels(32'h2835);
    rd(32'h04);
    check(rd_q, 32'h02404054);
    wr(32'h0C, 32'h0);
    levels(32'h0);
    rd(32'h0C);
    check(rd_q, 32'h0);
    n = pulse_cnt;
    wr(32'h0, 32'h1);
    repeat (4) @(posedge sys_clk);
    check(pulse_cnt - n, 32'h0);
    foreach (words[i])
    begin
      wr(32'h10, {16'h0, words[i]});
      rd(32'h14);
      check(rd_q, {16'h0, words[i]});
      rd(32'h18);
      check(rd_q, {{16{words[i][15]}}, words[i]});
    end
    wr(32'h40, 32'hA5A5A5A5);
    rd(32'h40);
    check(rd_q, 32'h0);
    check(hresp, 32'h0);
    check(hreadyout, 32'h1);
    results();
  end
endmodule
